/* src/pxic_ctrl.sv */
// Overview of operation
// R1: software picks whether the interrupt pin asserts high or low.
// R2: in level mode the interrupt output stays asserted until software clears the status bit.
// R3: host selects which events interrupt; status bits name the source.
// R4: control 0x10-11, enable 0x12-13, status 0x14-15; pointer auto-increments.
// R5: 24-bit pin enable at 0x16..0x18, high byte first.
// R6: 24-bit pin status at 0x19..0x1b, high byte first.
// R7: only control bits 2:0 writable; bits 15:3 read as zero.
// R8: global gate bit 0 high lets enabled interrupts out, low blocks all.
// R9: writing the global gate leaves the source enable mask alone.
// R10: control bit 1 selects level (0) or edge (1) output.
// R11: control bit 2 selects active low/falling (0) or high/rising (1).
// R12: source bits 8:0 are wakeup, keypad, overflow, rotator, overflow, pwm0-2, gpio.
// R13: status sets regardless of enable; only enabled sources drive output.
// R14: writing 1 clears a status bit, writing 0 leaves it.
// R15: pin enable bit n belongs to general-purpose pin n.
// R16: edge mode gives one pulse per new enabled status bit; the logic restarts a running pulse, and bits new in one cycle share one.
// R17: everything resets to zero; output deasserted, level, active low.
`timescale 1ns/1ps
module pxic_ctrl
    import pxic_pkg::*;
#(
    parameter int SRC_W = 9,
    parameter int PIN_W = 24
) (
    input  wire logic             clk_sys_i,
    input  wire logic             nrst_i,
    input  wire logic             reg_start_i,
    input  wire logic [7:0]       reg_addr_i,
    input  wire logic             reg_wr_i,
    input  wire logic [7:0]       reg_wdata_i,
    input  wire logic             reg_rd_i,
    output logic      [7:0]       reg_rdata_o,
    output logic                  reg_rvalid_o,
    input  wire logic [SRC_W-1:0] src_event_i,
    input  wire logic [PIN_W-1:0] pin_event_i,
    output logic                  int_o
);
    import pxic_pkg::*;

    generate
        if (SRC_W < SRC_GPIO + 1 || SRC_W > 16 || PIN_W < 1 || PIN_W > 24) begin : g_bad_param
            $error("pxic_ctrl: SRC_W must be 9..16 and PIN_W 1..24");
        end
    endgenerate

    // ****************************************************************
    // register state
    // ****************************************************************
    logic [CTRL_W-1:0]     ctrl_r;
    logic [CTRL_W-1:0]     ctrl_nxt;
    logic [SRC_W-1:0]      src_en_r;
    logic [SRC_W-1:0]      src_en_nxt;
    logic [PIN_W-1:0]      pin_en_r;
    logic [PIN_W-1:0]      pin_en_nxt;
    logic [7:0]            ptr_r;
    logic [7:0]            ptr_nxt;
    logic [7:0]            rdata_r;
    logic [7:0]            rdata_nxt;
    logic                  rvalid_r;
    logic                  rvalid_nxt;
    logic [EDGE_CNT_W-1:0] edge_cnt_r;
    logic [EDGE_CNT_W-1:0] edge_cnt_nxt;
    logic                  int_out_r;
    logic                  int_out_nxt;

    logic [15:0]           src_en16;
    logic [15:0]           src_st16;
    logic [15:0]           src_clr16;
    logic [23:0]           pin_en24;
    logic [23:0]           pin_st24;
    logic [23:0]           pin_clr24;
    logic [SRC_W-1:0]      src_stat;
    logic [SRC_W-1:0]      src_set;
    logic [PIN_W-1:0]      pin_stat;
    logic                  src_new;
    logic                  wr_en;
    logic                  rd_en;
    logic                  gate_w;
    logic                  type_w;
    logic                  pol_w;
    logic                  pending_w;
    logic                  active_nxt;
    logic [7:0]            pin_st_hi;

    assign gate_w = ctrl_r[GLOBAL_GATE_BIT];
    assign type_w = ctrl_r[OUTPUT_TYPE_BIT];
    assign pol_w  = ctrl_r[OUTPUT_POLARITY_BIT];
    // a start wins over an access in the same cycle
    assign wr_en  = reg_wr_i & ~reg_start_i;
    assign rd_en  = reg_rd_i & ~reg_start_i;

    // zero-extended byte views of the registers
    assign src_en16 = 16'(src_en_r);
    assign src_st16 = 16'(src_stat);
    assign pin_en24 = 24'(pin_en_r);
    assign pin_st24 = 24'(pin_stat);
    assign pin_st_hi = pin_st24[23:16];

    // ****************************************************************
    // status banks
    // ****************************************************************
    // write-one-to-clear masks per byte
    always_comb begin
        src_clr16 = 16'h0000;
        pin_clr24 = 24'h000000;
        if (wr_en) begin
            case (ptr_r)
                SOURCE_STATUS_HIGH: src_clr16[15:8] = reg_wdata_i; // R14
                SOURCE_STATUS_LOW:  src_clr16[7:0]  = reg_wdata_i; // R14
                PIN_STATUS_HIGH:    pin_clr24[23:16] = reg_wdata_i; // R6
                PIN_STATUS_MID:     pin_clr24[15:8]  = reg_wdata_i; // R6
                PIN_STATUS_LOW:     pin_clr24[7:0]   = reg_wdata_i; // R6
                default: ;
            endcase
        end
    end

    // gpio source fires on any enabled pin event
    always_comb begin
        src_set           = src_event_i;
        src_set[SRC_GPIO] = src_event_i[SRC_GPIO] | (|(pin_event_i & pin_en_r)); // R12 R15
    end

    // status sets whatever the enables say
    pxic_status_bank #(
        .W (SRC_W)
    ) u_src_bank (
        .clk_sys_i (clk_sys_i),
        .nrst_i    (nrst_i),
        .set_i     (src_set), // R13
        .clr_i     (src_clr16[SRC_W-1:0]),
        .en_i      (src_en_r),
        .status_o  (src_stat),
        .new_o     (src_new)
    );

    // pin status is only read back; the gpio source takes the raw enabled pin events, so its new flag is unused
    pxic_status_bank #(
        .W (PIN_W)
    ) u_pin_bank (
        .clk_sys_i (clk_sys_i),
        .nrst_i    (nrst_i),
        .set_i     (pin_event_i),
        .clr_i     (pin_clr24[PIN_W-1:0]),
        .en_i      (pin_en_r),
        .status_o  (pin_stat),
        .new_o     ()
    );

    // ****************************************************************
    // register access
    // ****************************************************************
    // byte writes and reads at the pointer, which steps after each access
    always_comb begin
        ctrl_nxt   = ctrl_r;
        src_en_nxt = src_en_r;
        pin_en_nxt = pin_en_r;
        ptr_nxt    = ptr_r;
        rdata_nxt  = rdata_r;
        rvalid_nxt = rd_en;
        if (reg_start_i) begin
            ptr_nxt = reg_addr_i;
        end else if (wr_en || rd_en) begin
            ptr_nxt = ptr_r + 8'h01; // R4
        end
        if (wr_en) begin
            case (ptr_r)
                INT_CONTROL_LOW:    ctrl_nxt   = reg_wdata_i[CTRL_W-1:0]; // R7 R9
                SOURCE_ENABLE_HIGH: src_en_nxt = SRC_W'({reg_wdata_i, src_en16[7:0]}); // R3
                SOURCE_ENABLE_LOW:  src_en_nxt = SRC_W'({src_en16[15:8], reg_wdata_i}); // R3
                PIN_ENABLE_HIGH:    pin_en_nxt = PIN_W'({reg_wdata_i, pin_en24[15:0]}); // R5
                PIN_ENABLE_MID:     pin_en_nxt = PIN_W'({pin_en24[23:16], reg_wdata_i, pin_en24[7:0]}); // R5
                PIN_ENABLE_LOW:     pin_en_nxt = PIN_W'({pin_en24[23:8], reg_wdata_i}); // R5
                default: ;
            endcase
        end
        if (rd_en) begin
            case (ptr_r)
                INT_CONTROL_HIGH:   rdata_nxt = 8'h00; // R7
                INT_CONTROL_LOW:    rdata_nxt = {5'h00, ctrl_r}; // R7
                SOURCE_ENABLE_HIGH: rdata_nxt = src_en16[15:8];
                SOURCE_ENABLE_LOW:  rdata_nxt = src_en16[7:0];
                SOURCE_STATUS_HIGH: rdata_nxt = src_st16[15:8]; // R3
                SOURCE_STATUS_LOW:  rdata_nxt = src_st16[7:0]; // R3
                PIN_ENABLE_HIGH:    rdata_nxt = pin_en24[23:16];
                PIN_ENABLE_MID:     rdata_nxt = pin_en24[15:8];
                PIN_ENABLE_LOW:     rdata_nxt = pin_en24[7:0];
                PIN_STATUS_HIGH:    rdata_nxt = pin_st24[23:16]; // R6
                PIN_STATUS_MID:     rdata_nxt = pin_st24[15:8];
                PIN_STATUS_LOW:     rdata_nxt = pin_st24[7:0];
                default:            rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ctrl_r   <= CTRL_RESET; // R17
            src_en_r <= '0;
            pin_en_r <= '0;
            ptr_r    <= PTR_RESET;
            rdata_r  <= RDATA_RESET;
            rvalid_r <= 1'b0;
        end else begin
            ctrl_r   <= ctrl_nxt;
            src_en_r <= src_en_nxt;
            pin_en_r <= pin_en_nxt;
            ptr_r    <= ptr_nxt;
            rdata_r  <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
        end
    end

    assign reg_rdata_o  = rdata_r;
    assign reg_rvalid_o = rvalid_r;

    // ****************************************************************
    // interrupt output
    // ****************************************************************
    // edge mode restarts a fixed pulse on each new enabled status bit;
    // a new bit while one is still running reloads the count and stretches it;
    // closing the gate cuts a running pulse so nothing leaks out
    always_comb begin
        pending_w = gate_w & (|(src_stat & src_en_r)); // R8 R13
        if (!gate_w) begin
            edge_cnt_nxt = '0; // R8
        end else if (type_w && src_new) begin
            edge_cnt_nxt = EDGE_CNT_W'(EDGE_PULSE_CYC); // R16
        end else if (edge_cnt_r != '0) begin
            edge_cnt_nxt = edge_cnt_r - EDGE_CNT_W'(1);
        end else begin
            edge_cnt_nxt = '0;
        end
        active_nxt  = type_w ? (edge_cnt_nxt != '0) : pending_w; // R10 R2
        int_out_nxt = active_nxt ~^ pol_w; // R1 R11
    end

    // reset value is high: deasserted for active-low polarity
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            edge_cnt_r <= '0;
            int_out_r  <= 1'b1; // R17
        end else begin
            edge_cnt_r <= edge_cnt_nxt;
            int_out_r  <= int_out_nxt;
        end
    end

    assign int_o = int_out_r;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);

    a_level_follows: assert property ( // R2
        (!type_w && pending_w) |=> (int_o == $past(pol_w)))
        else $error("level interrupt not asserted while pending");

    a_gate_blocks: assert property ( // R8
        !gate_w |=> (int_o == !$past(pol_w)))
        else $error("interrupt escaped with global gate low");

    a_edge_starts: assert property ( // R16
        (gate_w && type_w && src_new) |=> (int_o == $past(pol_w)) && (edge_cnt_r == EDGE_CNT_W'(EDGE_PULSE_CYC)))
        else $error("edge pulse did not start");

    a_w1c_clears: assert property ( // R14
        (wr_en && ptr_r == SOURCE_STATUS_LOW && reg_wdata_i[SRC_WAKEUP] && !src_event_i[SRC_WAKEUP])
        |=> !src_stat[SRC_WAKEUP])
        else $error("status bit not cleared by a one");

    a_w0_keeps: assert property ( // R14
        (wr_en && ptr_r == SOURCE_STATUS_LOW && !reg_wdata_i[SRC_KEYPAD] && src_stat[SRC_KEYPAD])
        |=> src_stat[SRC_KEYPAD])
        else $error("status bit lost on writing zero");

    a_status_sets: assert property ( // R13
        src_event_i[SRC_ROTATOR] |=> src_stat[SRC_ROTATOR])
        else $error("status bit not set by its event");

    a_gate_keeps_en: assert property ( // R9
        (wr_en && ptr_r == INT_CONTROL_LOW) |=> (src_en_r == $past(src_en_r)))
        else $error("control write disturbed the enable mask");

    a_ctrl_masked: assert property ( // R7
        (rd_en && ptr_r == INT_CONTROL_LOW) |=> (reg_rdata_o[7:CTRL_W] == 5'h00) && reg_rvalid_o)
        else $error("reserved control bits read non-zero");

    a_ptr_steps: assert property ( // R4
        (!reg_start_i && (reg_wr_i || reg_rd_i)) |=> (ptr_r == $past(ptr_r) + 8'h01))
        else $error("pointer did not auto-increment");

    a_pin_read: assert property ( // R6
        (rd_en && ptr_r == PIN_STATUS_HIGH) |=> (reg_rdata_o == $past(pin_st_hi)))
        else $error("pin status high byte misread");

    a_gpio_route: assert property ( // R15
        (pin_event_i[0] && pin_en_r[0]) |=> src_stat[SRC_GPIO])
        else $error("enabled pin event did not reach gpio source");

endmodule

/* src/pxic_pkg.sv */
// ****************************************************************
// interrupt controller constants
// ****************************************************************
package pxic_pkg;

    // byte register map, auto-incrementing pointer
    localparam logic [7:0] INT_CONTROL_HIGH   = 8'h10;
    localparam logic [7:0] INT_CONTROL_LOW    = 8'h11;
    localparam logic [7:0] SOURCE_ENABLE_HIGH = 8'h12;
    localparam logic [7:0] SOURCE_ENABLE_LOW  = 8'h13;
    localparam logic [7:0] SOURCE_STATUS_HIGH = 8'h14;
    localparam logic [7:0] SOURCE_STATUS_LOW  = 8'h15;
    localparam logic [7:0] PIN_ENABLE_HIGH    = 8'h16;
    localparam logic [7:0] PIN_ENABLE_MID     = 8'h17;
    localparam logic [7:0] PIN_ENABLE_LOW     = 8'h18;
    localparam logic [7:0] PIN_STATUS_HIGH    = 8'h19;
    localparam logic [7:0] PIN_STATUS_MID     = 8'h1a;
    localparam logic [7:0] PIN_STATUS_LOW     = 8'h1b;

    // control field positions
    localparam int GLOBAL_GATE_BIT     = 0;
    localparam int OUTPUT_TYPE_BIT     = 1;
    localparam int OUTPUT_POLARITY_BIT = 2;
    localparam int CTRL_W              = 3;

    // source bit positions
    localparam int SRC_WAKEUP   = 0;
    localparam int SRC_KEYPAD   = 1;
    localparam int SRC_KEY_OVF  = 2;
    localparam int SRC_ROTATOR  = 3;
    localparam int SRC_ROT_OVF  = 4;
    localparam int SRC_PWM0     = 5;
    localparam int SRC_PWM1     = 6;
    localparam int SRC_PWM2     = 7;
    localparam int SRC_GPIO     = 8;

    // reset values
    localparam logic [CTRL_W-1:0] CTRL_RESET   = 3'h0;
    localparam logic [7:0]        RDATA_RESET  = 8'h00;
    localparam logic [7:0]        PTR_RESET    = 8'h00;

    // edge-mode pulse width
    localparam int CLK_PERIOD_NS   = 40;
    localparam int EDGE_PULSE_NS   = 1000;
    localparam int EDGE_PULSE_CYC  = (EDGE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int EDGE_CNT_W      = $clog2(EDGE_PULSE_CYC + 1);

endpackage

/* src/pxic_status_bank.sv */
`timescale 1ns/1ps
// ****************************************************************
// sticky write-one-to-clear status bits
// ****************************************************************
module pxic_status_bank #(
    parameter int W = 9
) (
    input  wire logic         clk_sys_i,
    input  wire logic         nrst_i,
    input  wire logic [W-1:0] set_i,
    input  wire logic [W-1:0] clr_i,
    input  wire logic [W-1:0] en_i,
    output logic      [W-1:0] status_o,
    output logic              new_o
);

    generate
        if (W < 1) begin : g_bad_width
            $error("pxic_status_bank: W must be at least 1");
        end
    endgenerate

    logic [W-1:0] status_r;
    logic [W-1:0] status_nxt;

    // set wins over a clear in the same cycle so no event is lost
    always_comb begin
        status_nxt = (status_r & ~clr_i) | set_i;
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            status_r <= '0;
        end else begin
            status_r <= status_nxt;
        end
    end

    assign status_o = status_r;
    // an enabled bit going from clear to set
    assign new_o    = |(set_i & en_i & (~status_r | clr_i));

endmodule

/* sim/pxic_host_model.sv */
`timescale 1ns/1ps
// ****************************************************************
// host side: watches the interrupt pin
// ****************************************************************
module pxic_host_model (
    input  wire logic clk_sys_i,
    input  wire logic nrst_i,
    input  wire logic int_i,
    input  wire logic act_high_i,
    output int        hits_o,
    output int        width_o
);
    logic prev_r;

    // counts assertions and their width; a polarity change mid-run may count once
    always @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            hits_o  <= 0;
            width_o <= 0;
            prev_r  <= 1'b0;
        end else begin
            prev_r <= (int_i == act_high_i);
            if ((int_i == act_high_i) && !prev_r) begin
                hits_o  <= hits_o + 1;
                width_o <= 1;
            end else if (int_i == act_high_i) begin
                width_o <= width_o + 1;
            end
        end
    end
endmodule

/* sim/tb.sv */
`timescale 1ns/1ps
// ****************************************************************
// register port and interrupt pin bench
// ****************************************************************
module tb;
    import pxic_pkg::*;
    logic        clk_sys_i = 1'b0;
    logic        nrst_i    = 1'b0;
    logic        reg_start = 1'b0;
    logic [7:0]  reg_addr  = 8'h00;
    logic        reg_wr    = 1'b0;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_rd    = 1'b0;
    logic [7:0]  reg_rdata;
    logic        reg_rvalid;
    logic [8:0]  src_event = 9'h000;
    logic [23:0] pin_event = 24'h000000;
    logic        int_pin;
    logic        act_high  = 1'b0;
    logic [15:0] m;
    int          hits;
    int          width;
    int          h0;
    int          miscompares  = 0;
    int          total_checks = 0;

    // 25 MHz
    always #20 clk_sys_i = ~clk_sys_i;

    pxic_ctrl u_dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .reg_start_i(reg_start),
        .reg_addr_i(reg_addr), .reg_wr_i(reg_wr), .reg_wdata_i(reg_wdata), .reg_rd_i(reg_rd),
        .reg_rdata_o(reg_rdata), .reg_rvalid_o(reg_rvalid), .src_event_i(src_event),
        .pin_event_i(pin_event), .int_o(int_pin));

    pxic_host_model u_host (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .int_i(int_pin),
        .act_high_i(act_high), .hits_o(hits), .width_o(width));

    task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_bit(input string what, input logic exp, input logic got);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic chk_num(input string what, input int exp, input int got);
        total_checks++;
        if (got != exp) begin
            miscompares++;
            $display("mismatch %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    // pointer load; every access starts a cycle apart so no strobe is set twice in a step
    task automatic seek(input logic [7:0] a);
        @(negedge clk_sys_i);
        reg_start = 1'b1;
        reg_addr  = a;
        @(negedge clk_sys_i);
        reg_start = 1'b0;
    endtask

    task automatic put(input logic [7:0] d);
        @(negedge clk_sys_i);
        reg_wr    = 1'b1;
        reg_wdata = d;
        @(negedge clk_sys_i);
        reg_wr = 1'b0;
    endtask

    // read data lands the cycle after the strobe edge
    task automatic get(input string what, input logic [7:0] exp);
        @(negedge clk_sys_i);
        reg_rd = 1'b1;
        @(negedge clk_sys_i);
        reg_rd = 1'b0;
        chk_bit({what, " valid"}, 1'b1, reg_rvalid);
        chk_byte(what, exp, reg_rdata);
    endtask

    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        seek(a);
        put(d);
    endtask

    task automatic wsts(input logic [15:0] v);
        seek(SOURCE_STATUS_HIGH);
        put(v[15:8]);
        put(v[7:0]);
    endtask

    task automatic rsts(input logic [15:0] e);
        seek(SOURCE_STATUS_HIGH);
        get("status high", e[15:8]);
        get("status low", e[7:0]);
    endtask

    task automatic fire(input logic [8:0] s, input logic [23:0] p);
        @(negedge clk_sys_i);
        src_event = s;
        pin_event = p;
        @(negedge clk_sys_i);
        src_event = 9'h000;
        pin_event = 24'h000000;
    endtask

    task automatic summarize();
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // watchdog: the tests need under 600 cycles
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        miscompares++;
        summarize();
    end

    initial begin
        repeat (4) @(negedge clk_sys_i);
        nrst_i = 1'b1;
        chk_bit("int after reset", 1'b1, int_pin);
        seek(INT_CONTROL_HIGH);
        for (int i = 0; i < 12; i++) begin
            get("reset byte", 8'h00);
        end
        wreg(INT_CONTROL_HIGH, 8'hff);
        seek(INT_CONTROL_HIGH);
        get("ctrl high", 8'h00);
        get("ctrl low", 8'h00);
        wreg(INT_CONTROL_LOW, 8'hff);
        seek(INT_CONTROL_LOW);
        get("ctrl low", 8'h07);
        // burst write, then a read that lands in status, proving the pointer step
        seek(SOURCE_ENABLE_HIGH);
        put(8'hff);
        put(8'h0a);
        get("status high", 8'h00);
        wreg(INT_CONTROL_LOW, 8'h00);
        seek(SOURCE_ENABLE_HIGH);
        get("enable high", 8'h01);
        get("enable low", 8'h0a);
        wreg(8'h20, 8'hff);
        seek(8'h20);
        get("unmapped", 8'h00);
        // each source sets its own bit, gate closed
        for (int i = 0; i < 9; i++) begin
            m = 16'h0001 << i;
            fire(m[8:0], 24'h000000);
            wsts(~m);
            rsts(m);
            chk_bit("gated", 1'b1, int_pin);
            wsts(m);
            rsts(16'h0000);
        end
        wreg(INT_CONTROL_LOW, 8'h05);
        act_high = 1'b1;
        fire(9'h002, 24'h000000);
        repeat (3) @(negedge clk_sys_i);
        chk_bit("level on", 1'b1, int_pin);
        repeat (20) @(negedge clk_sys_i);
        chk_bit("level held", 1'b1, int_pin);
        wreg(INT_CONTROL_LOW, 8'h04);
        repeat (2) @(negedge clk_sys_i);
        chk_bit("gate off", 1'b0, int_pin);
        wreg(INT_CONTROL_LOW, 8'h01);
        act_high = 1'b0;
        repeat (2) @(negedge clk_sys_i);
        chk_bit("active low", 1'b0, int_pin);
        wsts(16'h0002);
        repeat (2) @(negedge clk_sys_i);
        chk_bit("cleared", 1'b1, int_pin);
        fire(9'h001, 24'h000000);
        repeat (3) @(negedge clk_sys_i);
        chk_bit("disabled source", 1'b1, int_pin);
        wsts(16'h0001);
        // edge mode: one fixed pulse per new enabled bit
        wreg(INT_CONTROL_LOW, 8'h07);
        act_high = 1'b1;
        repeat (3) @(negedge clk_sys_i);
        h0 = hits;
        fire(9'h008, 24'h000000);
        repeat (EDGE_PULSE_CYC + 10) @(negedge clk_sys_i);
        chk_num("edge count", h0 + 1, hits);
        chk_num("edge width", EDGE_PULSE_CYC, width);
        chk_bit("edge idle", 1'b0, int_pin);
        fire(9'h002, 24'h000000);
        repeat (EDGE_PULSE_CYC + 10) @(negedge clk_sys_i);
        chk_num("second edge", h0 + 2, hits);
        wsts(16'h000a);
        // falling edge, then a pulse cut short by closing the gate
        wreg(INT_CONTROL_LOW, 8'h03);
        act_high = 1'b0;
        repeat (3) @(negedge clk_sys_i);
        h0 = hits;
        fire(9'h008, 24'h000000);
        repeat (EDGE_PULSE_CYC + 10) @(negedge clk_sys_i);
        chk_num("falling edge count", h0 + 1, hits);
        chk_num("falling edge width", EDGE_PULSE_CYC, width);
        fire(9'h002, 24'h000000);
        wreg(INT_CONTROL_LOW, 8'h02);
        repeat (2) @(negedge clk_sys_i);
        chk_bit("edge gated", 1'b1, int_pin);
        wsts(16'h000a);
        // pin mask: pins 23 and 0 enabled
        seek(PIN_ENABLE_HIGH);
        put(8'h80);
        put(8'h00);
        put(8'h01);
        fire(9'h000, 24'h800002);
        seek(PIN_ENABLE_HIGH);
        get("pin en high", 8'h80);
        get("pin en mid", 8'h00);
        get("pin en low", 8'h01);
        get("pin st high", 8'h80);
        get("pin st mid", 8'h00);
        get("pin st low", 8'h02);
        rsts(16'h0100);
        summarize();
    end
endmodule
